// ---- include/cos_pkg.sv ----
`default_nettype none
package cos_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CLAMP_SRC = 6'h18;
  localparam logic [5:0] IDX_START = 6'h19;
  localparam logic [5:0] IDX_LENGTH = 6'h1A;
  localparam logic [5:0] IDX_POL_OFS = 6'h1B;
  localparam logic [5:0] IDX_SLICER = 6'h1D;
  // Reset values
  localparam logic [7:0] RST_CLAMP_SRC = 8'h20;
  localparam logic [7:0] RST_START = 8'h08;
  localparam logic [7:0] RST_LENGTH = 8'h14;
  localparam logic [7:0] RST_POL_OFS = 8'h5B;
  localparam logic [7:0] RST_SLICER = 8'h78;
  // Field positions
  localparam int BIT_EXT_CLAMP = 4;
  localparam int BIT_RED_MID = 3;
  localparam int BIT_GREEN_MID = 2;
  localparam int BIT_BLUE_MID = 1;
  localparam int BIT_POL_OVR = 7;
  localparam int BIT_POL_USER = 6;
  localparam int BIT_AUTO_OFS = 5;
  localparam int UPD_HI = 4;
  localparam int UPD_LO = 3;
  localparam int THR_HI = 7;
  localparam int THR_LO = 3;
  localparam int BIT_OUT_POL = 2;
  localparam int SEL_HI = 1;
  localparam int SEL_LO = 0;
  // Offset update intervals in clamp periods, or once per frame
  localparam logic [5:0] UPD_EVERY_16 = 6'h0F;
  localparam logic [5:0] UPD_EVERY_64 = 6'h3F;
  localparam logic [1:0] UPD_CLAMP = 2'h0;
  localparam logic [1:0] UPD_16 = 2'h1;
  localparam logic [1:0] UPD_64 = 2'h2;
  localparam logic [1:0] UPD_FRAME = 2'h3;
  // Sliced sync output choices
  localparam logic [1:0] SEL_RAW_GREEN = 2'h0;
  localparam logic [1:0] SEL_RAW_LINE = 2'h1;
  localparam logic [1:0] SEL_REGEN = 2'h2;
  localparam logic [1:0] SEL_FILTERED = 2'h3;
  localparam int POL_CNT_W = 16;
  typedef enum logic [1:0] {CLAMP_IDLE, CLAMP_WAIT, CLAMP_PULSE} cos_clamp_state_t;
endpackage
`default_nettype wire

// ---- design/cos_clamp_offset_sync.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module cos_clamp_offset_sync
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cos_pkg::ADDR_W-1:0] paddr,
  input wire logic [cos_pkg::DATA_W-1:0] pwdata,
  output logic [cos_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lineSyncIn,
  input wire logic externalClampIn,
  input wire logic greenEmbeddedSyncIn,
  input wire logic frameSyncIn,
  input wire logic regenSyncIn,
  input wire logic filteredSyncIn,
  output logic clampActive,
  output logic [2:0] clampMidscale,
  output logic autoOffsetEnable,
  output logic offsetUpdate,
  output logic [4:0] slicerThreshold,
  output logic slicedSyncOutput
);
  import cos_pkg::*;

  logic [7:0] clampSrcReg;
  logic [7:0] startDelay;
  logic [7:0] pulseLength;
  logic [7:0] polOfsReg;
  logic [7:0] slicerReg;
  logic [5:0] regIndex;
  logic addrHit;
  logic [7:0] readByte;
  logic wrEn;

  // Pin inputs pass two flip-flops before use
  logic [1:0] lineSyncMeta;
  logic [1:0] extClampMeta;
  logic [1:0] greenMeta;
  logic [1:0] frameMeta;
  logic lineSyncDly;
  logic frameDly;
  logic lineEnd;
  logic frameStart;

  cos_clamp_state_t clampState;
  logic [7:0] clampCount;
  logic internalClamp;

  logic [POL_CNT_W-1:0] highCount;
  logic [POL_CNT_W-1:0] lowCount;
  logic autoActiveHigh;
  logic clampActiveHigh;
  logic externalClamp;
  logic next_clampActive;
  logic clampDly;
  logic clampEnd;
  logic [5:0] periodCount;
  logic selectedSync;

  assign regIndex = paddr[7:2];
  assign addrHit = (paddr[1:0] == 2'h0) &&
    (regIndex == IDX_CLAMP_SRC || regIndex == IDX_START || regIndex == IDX_LENGTH ||
     regIndex == IDX_POL_OFS || regIndex == IDX_SLICER);
  assign wrEn = psel && penable && pwrite && addrHit;

  // Zero-wait slave: read data is captured in the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addrHit;

  // Read mux; unmapped indices read as zero
  always_comb
  begin
    case (regIndex)
      IDX_CLAMP_SRC: readByte = clampSrcReg;
      IDX_START: readByte = startDelay;
      IDX_LENGTH: readByte = pulseLength;
      IDX_POL_OFS: readByte = polOfsReg;
      IDX_SLICER: readByte = slicerReg;
      default: readByte = 8'h00;
    endcase
  end

  // Read data loads in setup so it stands through access
  always_ff @(posedge clk)
  begin
    if (reset)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= (paddr[1:0] == 2'h0) ? {24'h000000, readByte} : 32'h00000000;
  end

  // Register file; only the low byte of write data is kept
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clampSrcReg <= RST_CLAMP_SRC;
      startDelay <= RST_START;
      pulseLength <= RST_LENGTH;
      polOfsReg <= RST_POL_OFS;
      slicerReg <= RST_SLICER;
    end
    else if (wrEn)
    begin
      case (regIndex)
        IDX_CLAMP_SRC: clampSrcReg <= pwdata[7:0];
        IDX_START: startDelay <= pwdata[7:0];
        IDX_LENGTH: pulseLength <= pwdata[7:0];
        IDX_POL_OFS: polOfsReg <= pwdata[7:0];
        IDX_SLICER: slicerReg <= pwdata[7:0];
        default: clampSrcReg <= clampSrcReg;
      endcase
    end
  end

  // Two-stage synchronisers on the pin inputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lineSyncMeta <= 2'h0;
      extClampMeta <= 2'h0;
      greenMeta <= 2'h0;
      frameMeta <= 2'h0;
    end
    else
    begin
      lineSyncMeta <= {lineSyncMeta[0], lineSyncIn};
      extClampMeta <= {extClampMeta[0], externalClampIn};
      greenMeta <= {greenMeta[0], greenEmbeddedSyncIn};
      frameMeta <= {frameMeta[0], frameSyncIn};
    end
  end

  // Edge detect flops read only the second stage
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lineSyncDly <= 1'b0;
      frameDly <= 1'b0;
    end
    else
    begin
      lineSyncDly <= lineSyncMeta[1];
      frameDly <= frameMeta[1];
    end
  end

  // Line sync arrives active high; its falling edge ends the pulse
  assign lineEnd = lineSyncDly && !lineSyncMeta[1];
  assign frameStart = frameMeta[1] && !frameDly;

  // Internal clamp timing: delay then pulse, rearmed on each line
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clampState <= CLAMP_IDLE;
      clampCount <= 8'h00;
    end
    else if (lineEnd)
    begin
      clampState <= CLAMP_WAIT;
      clampCount <= startDelay;
    end
    else
    begin
      case (clampState)
        CLAMP_WAIT:
          if (clampCount <= 8'h01)
          begin
            clampState <= CLAMP_PULSE;
            clampCount <= pulseLength;
          end
          else
            clampCount <= clampCount - 8'h01;
        CLAMP_PULSE:
          if (clampCount <= 8'h01)
            clampState <= CLAMP_IDLE;
          else
            clampCount <= clampCount - 8'h01;
        CLAMP_IDLE:
          clampCount <= 8'h00;
        default:
          clampState <= CLAMP_IDLE;
      endcase
    end
  end

  assign internalClamp = (clampState == CLAMP_PULSE);

  // Automatic polarity: the level held for less of the line is active
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      highCount <= '0;
      lowCount <= '0;
      autoActiveHigh <= 1'b1;
    end
    else if (lineEnd)
    begin
      autoActiveHigh <= (highCount < lowCount);
      highCount <= '0;
      lowCount <= '0;
    end
    else if (extClampMeta[1])
    begin
      if (highCount != '1)
        highCount <= highCount + 1'b1;
    end
    else if (lowCount != '1)
      lowCount <= lowCount + 1'b1;
  end

  assign clampActiveHigh = polOfsReg[BIT_POL_OVR] ? polOfsReg[BIT_POL_USER]
                                                   : autoActiveHigh;
  assign externalClamp = clampActiveHigh ? extClampMeta[1] : !extClampMeta[1];
  // External source bypasses the placement and duration counters
  assign next_clampActive = clampSrcReg[BIT_EXT_CLAMP] ? externalClamp
                                                        : internalClamp;

  // One registered clamp drives all three channels
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clampActive <= 1'b0;
      clampDly <= 1'b0;
    end
    else
    begin
      clampActive <= next_clampActive;
      clampDly <= clampActive;
    end
  end

  // Clamp targets in red, green, blue order
  always_ff @(posedge clk)
  begin
    if (reset)
      clampMidscale <= 3'h0;
    else
      clampMidscale <= {clampSrcReg[BIT_RED_MID], clampSrcReg[BIT_GREEN_MID],
                        clampSrcReg[BIT_BLUE_MID]};
  end

  // One-cycle strobe as each clamp period closes
  assign clampEnd = clampDly && !clampActive;

  // Offset update strobe paced by clamp periods or frame sync
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      autoOffsetEnable <= 1'b0;
      offsetUpdate <= 1'b0;
      periodCount <= 6'h00;
    end
    else
    begin
      autoOffsetEnable <= polOfsReg[BIT_AUTO_OFS];
      offsetUpdate <= 1'b0;
      if (!polOfsReg[BIT_AUTO_OFS])
        periodCount <= 6'h00;
      else
      begin
        case (polOfsReg[UPD_HI:UPD_LO])
          UPD_CLAMP:
            offsetUpdate <= clampEnd;
          UPD_16:
            if (clampEnd)
            begin
              offsetUpdate <= (periodCount[3:0] == UPD_EVERY_16[3:0]);
              periodCount <= {2'h0, periodCount[3:0] + 4'h1};
            end
          UPD_64:
            if (clampEnd)
            begin
              offsetUpdate <= (periodCount == UPD_EVERY_64);
              periodCount <= periodCount + 6'h01;
            end
          UPD_FRAME:
            offsetUpdate <= frameStart;
          default:
            offsetUpdate <= 1'b0;
        endcase
      end
    end
  end

  // Code n sets a level of n plus one steps
  always_ff @(posedge clk)
  begin
    if (reset)
      slicerThreshold <= RST_SLICER[THR_HI:THR_LO];
    else
      slicerThreshold <= slicerReg[THR_HI:THR_LO];
  end

  // Regenerated and filtered choices come from the on-chip sync filter
  always_comb
  begin
    case (slicerReg[SEL_HI:SEL_LO])
      SEL_RAW_GREEN: selectedSync = greenMeta[1];
      SEL_RAW_LINE: selectedSync = lineSyncMeta[1];
      SEL_REGEN: selectedSync = regenSyncIn;
      SEL_FILTERED: selectedSync = filteredSyncIn;
      default: selectedSync = greenMeta[1];
    endcase
  end

  // Idle level is high while the active-high reset is asserted
  always_ff @(posedge clk)
  begin
    if (reset)
      slicedSyncOutput <= 1'b1;
    else
      slicedSyncOutput <= slicerReg[BIT_OUT_POL] ? selectedSync : !selectedSync;
  end
endmodule
`default_nettype wire

// ---- verification/cos_clamp_offset_sync_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module cos_clamp_offset_sync_chk
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cos_pkg::ADDR_W-1:0] paddr,
  input wire logic [cos_pkg::DATA_W-1:0] pwdata,
  input wire logic lineSyncIn,
  input wire logic externalClampIn,
  input wire logic greenEmbeddedSyncIn,
  input wire logic regenSyncIn,
  input wire logic filteredSyncIn,
  input wire logic clampActive,
  input wire logic [2:0] clampMidscale,
  input wire logic autoOffsetEnable,
  input wire logic offsetUpdate,
  input wire logic [4:0] slicerThreshold,
  input wire logic slicedSyncOutput
);
  import cos_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [7:0] src, st, ln, pol, slc;
  logic [8:0] age, hi, since;
  logic [2:0] dG, dL, dE;
  logic dR, dF, pick, okS, okL;
  // Input delay lines matching the synchroniser latency
  always_ff @(posedge clk)
  begin
    dG <= {dG[1:0], greenEmbeddedSyncIn};
    dL <= {dL[1:0], lineSyncIn};
    dE <= {dE[1:0], externalClampIn};
    dR <= regenSyncIn;
    dF <= filteredSyncIn;
    hi <= clampActive ? hi + 9'h001 : 9'h000;
    since <= (dL[0] && !lineSyncIn) ? 9'h001 : since + 9'h001;
  end
  // Register shadow and cycles since the last write
  always_ff @(posedge clk)
  begin
    age <= (age == 9'h1FF) ? age : age + 9'h001;
    if (reset)
    begin
      src <= RST_CLAMP_SRC;
      st <= RST_START;
      ln <= RST_LENGTH;
      pol <= RST_POL_OFS;
      slc <= RST_SLICER;
      age <= 9'h000;
    end
    else if (psel && penable && pwrite)
    begin
      age <= 9'h000;
      if (paddr == {IDX_CLAMP_SRC, 2'b00})
        src <= pwdata[7:0];
      if (paddr == {IDX_START, 2'b00})
        st <= pwdata[7:0];
      if (paddr == {IDX_LENGTH, 2'b00})
        ln <= pwdata[7:0];
      if (paddr == {IDX_POL_OFS, 2'b00})
        pol <= pwdata[7:0];
      if (paddr == {IDX_SLICER, 2'b00})
        slc <= pwdata[7:0];
    end
  end
  assign okS = age > 9'h004;
  assign okL = age > 9'h12C;
  assign pick = slc[1:0] == SEL_RAW_GREEN ? dG[2] : slc[1:0] == SEL_RAW_LINE ? dL[2] :
    slc[1:0] == SEL_REGEN ? dR : dF;
  chk_clamp_target: assert property (okS |-> clampMidscale == src[3:1])
    else $error("clamp target wrong");
  chk_auto_copy: assert property (okS |-> autoOffsetEnable == pol[5])
    else $error("auto offset enable wrong");
  chk_thr_copy: assert property (okS |-> slicerThreshold == slc[7:3])
    else $error("threshold wrong");
  chk_sync_route: assert property (okS
    |-> slicedSyncOutput == (pick ~^ slc[2]))
    else $error("sliced sync wrong");
  chk_ext_follow: assert property (okS && src[4] && pol[7]
    |-> clampActive == (dE[2] ~^ pol[6]))
    else $error("external clamp wrong");
  chk_int_start: assert property (okL && !src[4] && $rose(clampActive)
    |-> since == {1'b0, st} + 9'h004)
    else $error("clamp start wrong");
  chk_int_length: assert property (okL && !src[4] && $fell(clampActive)
    |-> hi == {1'b0, ln})
    else $error("clamp length wrong");
  chk_upd_gate: assert property (offsetUpdate |-> autoOffsetEnable)
    else $error("update while disabled");
  chk_upd_clamp: assert property (okL && pol[5] && pol[4:3] == UPD_CLAMP
    && $fell(clampActive) |-> ##[0:1] offsetUpdate)
    else $error("update missing");
  cov_ext: cover property (src[4] && $rose(clampActive));
  cov_int: cover property (!src[4] && $fell(clampActive));
  cov_upd: cover property (offsetUpdate);
endmodule
bind cos_clamp_offset_sync cos_clamp_offset_sync_chk i_cos_clamp_offset_sync_chk
(
  .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .lineSyncIn, .externalClampIn,
  .greenEmbeddedSyncIn, .regenSyncIn, .filteredSyncIn, .clampActive, .clampMidscale,
  .autoOffsetEnable, .offsetUpdate, .slicerThreshold, .slicedSyncOutput
);
`default_nettype wire

// ---- verification/cos_video_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module cos_video_src
(
  input wire logic clk,
  output logic lineSync,
  output logic greenSync,
  output logic frameSync,
  output logic regenSync,
  output logic filteredSync
);
  // Free running 300-pixel lines, 16 lines a frame
  logic [8:0] pix = 9'h000;
  logic [3:0] line = 4'h0;
  always @(posedge clk)
  begin
    pix <= (pix == 9'h12B) ? 9'h000 : pix + 9'h001;
    if (pix == 9'h12B)
      line <= line + 4'h1;
  end
  assign lineSync = pix < 9'h00C;
  assign greenSync = ~lineSync;
  assign frameSync = (line == 4'h0) && (pix < 9'h028);
  assign regenSync = pix[2];
  assign filteredSync = pix[1] ^ pix[4];
endmodule
`default_nettype wire

// ---- verification/tb_cos_clamp_offset_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_cos_clamp_offset_sync;
  import cos_pkg::*;
  localparam logic [7:0] A_SRC = {IDX_CLAMP_SRC, 2'b00};
  localparam logic [7:0] A_ST = {IDX_START, 2'b00};
  localparam logic [7:0] A_LEN = {IDX_LENGTH, 2'b00};
  localparam logic [7:0] A_POL = {IDX_POL_OFS, 2'b00};
  localparam logic [7:0] A_SLC = {IDX_SLICER, 2'b00};
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, extIn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, lineSyncIn, greenIn, frameIn, regenIn, filtIn;
  logic clampActive, autoOffsetEnable, offsetUpdate, slicedSyncOutput;
  logic [2:0] clampMidscale;
  logic [4:0] slicerThreshold;
  int error_cnt = 0, checked = 0;
  always #20 clk = ~clk;
  cos_video_src i_cos_video_src (.clk, .lineSync(lineSyncIn), .greenSync(greenIn),
    .frameSync(frameIn), .regenSync(regenIn), .filteredSync(filtIn));
  cos_clamp_offset_sync i_cos_clamp_offset_sync (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .lineSyncIn, .externalClampIn(extIn),
    .greenEmbeddedSyncIn(greenIn), .frameSyncIn(frameIn), .regenSyncIn(regenIn),
    .filteredSyncIn(filtIn), .clampActive, .clampMidscale, .autoOffsetEnable,
    .offsetUpdate, .slicerThreshold, .slicedSyncOutput);
  task automatic complete_run();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    cmp("pready in setup", 32'h0, {31'h0, pready});
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic span(input logic lvl, output int t);
    t = 0;
    while (clampActive === lvl && t < 600)
    begin
      @(posedge clk);
      t++;
    end
  endtask
  task automatic line_fall();
    while (lineSyncIn !== 1'b1) @(posedge clk);
    while (lineSyncIn !== 1'b0) @(posedge clk);
  endtask
  initial
  begin
    #(40 * 80000);
    error_cnt++;
    complete_run();
  end
  initial
  begin
    logic [7:0] ra [5];
    logic [7:0] re [5];
    int pv [4], lv [4], nl [4], ne [4], t, cnt;
    ra = '{A_SRC, A_ST, A_LEN, A_POL, A_SLC};
    re = '{RST_CLAMP_SRC, RST_START, RST_LENGTH, RST_POL_OFS, RST_SLICER};
    pv = '{8, 1, 20, 255};
    lv = '{20, 1, 255, 20};
    nl = '{4, 32, 64, 64};
    ne = '{4, 2, 1, 4};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    cmp("threshold", 32'h0F, {27'h0, slicerThreshold});
    cmp("sliced idle", 32'h1, {31'h0, slicedSyncOutput});
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      cmp("reset value", {24'h0, re[i]}, rd);
    end
    apb(1'b1, 8'h70, 32'hFF);
    apb(1'b0, 8'h70, 32'h0);
    cmp("unmapped", 32'h1, {rd[30:0], err});
    for (int i = 1; i < 8; i += 3)
    begin
      apb(1'b1, A_SRC, {27'h0, i[2:0], 1'b0});
      repeat (3) @(posedge clk);
      cmp("clamp target", i, {29'h0, clampMidscale});
    end
    for (int p = 0; p < 2; p++)
      for (int v = 0; v < 2; v++)
      begin
        apb(1'b1, A_SRC, 32'h10);
        apb(1'b1, A_POL, {24'h0, 1'b1, p[0], 6'h1B});
        extIn <= v[0];
        repeat (6) @(posedge clk);
        cmp("ext clamp", {31'h0, v[0] ~^ p[0]}, {31'h0, clampActive});
      end
    // Pin held high for a whole line: automatic polarity picks active low
    apb(1'b1, A_POL, 32'h1B);
    line_fall();
    line_fall();
    repeat (6) @(posedge clk);
    cmp("auto polarity", 32'h0, {31'h0, clampActive});
    extIn <= 1'b0;
    repeat (6) @(posedge clk);
    cmp("auto polarity", 32'h1, {31'h0, clampActive});
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, A_SLC, {24'h0, s[2] ? 5'h1F : 5'h00, s[2:0]});
      repeat (20) @(posedge clk);
      cmp("threshold", s[2] ? 32'h1F : 32'h0, {27'h0, slicerThreshold});
    end
    apb(1'b1, A_SRC, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, A_ST, pv[i]);
      apb(1'b1, A_LEN, lv[i]);
      apb(1'b0, A_ST, 32'h0);
      cmp("placement", pv[i], rd);
      line_fall();
      span(1'b0, t);
      cmp("clamp start", pv[i] + 4, t);
      span(1'b1, t);
      cmp("clamp length", lv[i], t);
    end
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, A_POL, {27'h2, m[1:0], 3'h3});
      line_fall();
      apb(1'b1, A_POL, {27'h3, m[1:0], 3'h3});
      cnt = 0;
      repeat (nl[m] * 300)
      begin
        @(posedge clk);
        cnt += (offsetUpdate === 1'b1);
      end
      cmp("offset updates", ne[m], cnt);
      cmp("auto offset", 32'h1, {31'h0, autoOffsetEnable});
    end
    complete_run();
  end
endmodule
`default_nettype wire
